// ---- rtl/srp_status.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.svh"

module srp_status (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              psc_flag,
    input  wire logic [7:0]        kept_sre,
    input  wire logic [7:0]        kept_ese,
    input  wire logic [7:0]        kept_ppe,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire srp_pkg::srp_op_e  cmd_op,
    input  wire logic [4:0]        cmd_sel,
    input  wire logic [15:0]       cmd_data,
    output logic                   resp_valid,
    output logic      [15:0]       resp_data,
    input  wire logic              msg_term,
    input  wire logic              dev_clear,
    input  wire logic [15:0]       oper_cond,
    input  wire logic [15:0]       qa_cond,
    input  wire logic [15:0]       lim_cond,
    input  wire logic              trace1_fail,
    input  wire logic [7:0]        esr_set,
    input  wire logic              out_avail,
    input  wire logic              err_push,
    input  wire logic [15:0]       err_code,
    input  wire logic              ser_poll,
    output logic                   poll_valid,
    output logic      [7:0]        poll_data,
    input  wire logic              par_poll,
    output logic                   pp_line_o,
    output logic                   pp_line_oe_n,
    output logic                   srq,
    output logic                   obuf_flush,
    output logic                   ibuf_flush,
    output logic                   cmd_abort
);

    srp_pkg::srp_state_s              q;
    srp_pkg::srp_state_s              d;
    logic [`SRP_NGRP-1:0][15:0]       cond;
    logic [`SRP_NGRP-1:0][15:0]       ev_set;
    logic [`SRP_NGRP-1:0]             grp_sum;
    logic [7:0]                       stb;
    logic                             event_summary_bit;
    logic                             mss;
    logic                             ist;
    logic [15:0]                      rd_val;
    logic                             take;
    logic                             is_read;
    logic                             is_write;
    logic                             err_pop;
    logic                             err_clr;
    logic [15:0]                      err_rdata;
    logic                             err_empty;
    logic [1:0]                       grp;
    logic [2:0]                       part;
    logic [1:0]                       gi;

    assign grp  = cmd_sel[4:3];
    assign part = cmd_sel[2:0];
    assign gi   = grp - 2'h1;

    always_comb begin
        cond                                         = '0;
        cond[`SRP_IDX_OPER]                          = oper_cond;
        cond[`SRP_IDX_LIM]                           = lim_cond;
        cond[`SRP_IDX_LIM][`SRP_LIM_TRACE1_BIT]      = trace1_fail;
        cond[`SRP_IDX_QA]                            = qa_cond;
        cond[`SRP_IDX_QA][`SRP_QA_LIM_BIT]           = grp_sum[`SRP_IDX_LIM];
    end

    always_comb begin
        for (int g = 0; g < `SRP_NGRP; g++) begin
            ev_set[g]  = (q.rise[g] & cond[g] & ~q.prev[g])
                       | (q.fall[g] & ~cond[g] & q.prev[g]);
            grp_sum[g] = |(q.ev[g] & q.en[g]);
        end
    end

    assign event_summary_bit = |(q.standard_event_status & q.event_status_enable_mask);

    always_comb begin
        stb                 = '0;
        stb[`SRP_STB_ERRQ]  = ~err_empty;
        stb[`SRP_STB_QA]    = grp_sum[`SRP_IDX_QA];
        stb[`SRP_STB_MAV]   = out_avail;
        stb[`SRP_STB_ESB]   = event_summary_bit;
        stb[`SRP_STB_OPER]  = grp_sum[`SRP_IDX_OPER];
        mss                 = |(stb & q.service_request_enable_mask & ~(8'h01 << `SRP_STB_MSS));
        stb[`SRP_STB_MSS]   = mss;
    end

    assign ist = (|(q.parallel_poll_enable_mask & stb)) ^ q.pp_inv;

    always_comb begin
        rd_val = '0;
        if (grp == `SRP_GRP_COMMON) begin
            if (part == `SRP_COM_STB) begin
                rd_val[7:0] = stb;
            end else if (part == `SRP_COM_ESR) begin
                rd_val[7:0] = q.standard_event_status;
            end else if (part == `SRP_COM_SRE) begin
                rd_val[7:0] = q.service_request_enable_mask;
            end else if (part == `SRP_COM_ESE) begin
                rd_val[7:0] = q.event_status_enable_mask;
            end else if (part == `SRP_COM_PPE) begin
                rd_val[7:0] = q.parallel_poll_enable_mask;
            end else if (part == `SRP_COM_IST) begin
                rd_val[0] = ist;
            end
        end else if (part == `SRP_PART_COND) begin
            rd_val = cond[gi];
        end else if (part == `SRP_PART_EVENT) begin
            rd_val = q.ev[gi];
        end else if (part == `SRP_PART_ENABLE) begin
            rd_val = q.en[gi];
        end else if (part == `SRP_PART_RISE) begin
            rd_val = q.rise[gi];
        end else if (part == `SRP_PART_FALL) begin
            rd_val = q.fall[gi];
        end
    end

    assign cmd_ready = (q.state == srp_pkg::SRP_ST_IDLE);
    assign take      = cmd_valid && cmd_ready;
    assign is_read   = take && (cmd_op == srp_pkg::SRP_OP_READ);
    assign is_write  = take && (cmd_op == srp_pkg::SRP_OP_WRITE);
    assign err_pop   = take && (cmd_op == srp_pkg::SRP_OP_ERRQ);
    assign err_clr   = take && (cmd_op == srp_pkg::SRP_OP_CLS);

    always_comb begin
        d            = q;
        d.resp_valid = 1'b0;
        d.poll_valid = 1'b0;
        d.obuf_flush = 1'b0;
        d.ibuf_flush = 1'b0;
        d.cmd_abort  = 1'b0;
        d.prev       = cond;
        case (q.state)
            srp_pkg::SRP_ST_INIT: begin
                // Masks survive power-on only when the clear flag is low
                if (!psc_flag) begin
                    d.service_request_enable_mask = kept_sre;
                    d.event_status_enable_mask = kept_ese;
                    d.parallel_poll_enable_mask = kept_ppe;
                end
                d.state = srp_pkg::SRP_ST_IDLE;
            end
            srp_pkg::SRP_ST_ERRWAIT: begin
                d.resp_valid = 1'b1;
                d.resp_data  = q.err_empty ? `SRP_NO_ERROR : err_rdata;
                d.state      = srp_pkg::SRP_ST_IDLE;
            end
            default: begin
                d.state = srp_pkg::SRP_ST_IDLE;
            end
        endcase
        if (take) begin
            if (q.after_term) begin
                d.obuf_flush = 1'b1;
                d.after_term = 1'b0;
            end
            case (cmd_op)
                srp_pkg::SRP_OP_READ: begin
                    // value is the binary weight sum
                    d.resp_valid = 1'b1;
                    d.resp_data  = rd_val;
                    if (grp == `SRP_GRP_COMMON && part == `SRP_COM_ESR) begin
                        d.standard_event_status = `SRP_REG8_CLR;
                    end else if (grp != `SRP_GRP_COMMON && part == `SRP_PART_EVENT) begin
                        d.ev[gi] = `SRP_EV_CLR;
                    end
                end
                srp_pkg::SRP_OP_WRITE: begin
                    // 8-bit masks take the low byte
                    if (grp == `SRP_GRP_COMMON) begin
                        if (part == `SRP_COM_SRE) begin
                            d.service_request_enable_mask = cmd_data[7:0];
                        end else if (part == `SRP_COM_ESE) begin
                            d.event_status_enable_mask = cmd_data[7:0];
                        end else if (part == `SRP_COM_PPE) begin
                            d.parallel_poll_enable_mask = cmd_data[7:0];
                        end
                    end else if (part == `SRP_PART_ENABLE) begin
                        d.en[gi] = cmd_data;
                    end else if (part == `SRP_PART_RISE) begin
                        d.rise[gi] = cmd_data;
                    end else if (part == `SRP_PART_FALL) begin
                        d.fall[gi] = cmd_data;
                    end
                end
                srp_pkg::SRP_OP_CLS: begin
                    d.standard_event_status = `SRP_REG8_CLR;
                    for (int g = 0; g < `SRP_NGRP; g++) begin
                        d.ev[g] = `SRP_EV_CLR;
                    end
                end
                srp_pkg::SRP_OP_PRESET: begin
                    d.en[`SRP_IDX_OPER] = `SRP_EN_OPQA_PRESET;
                    d.en[`SRP_IDX_QA]   = `SRP_EN_OPQA_PRESET;
                    d.en[`SRP_IDX_LIM]  = `SRP_EN_OTHER_PRESET;
                    for (int g = 0; g < `SRP_NGRP; g++) begin
                        d.rise[g] = `SRP_RISE_PRESET;
                        d.fall[g] = `SRP_FALL_PRESET;
                    end
                end
                srp_pkg::SRP_OP_ERRQ: begin
                    d.err_empty = err_empty;
                    d.state     = srp_pkg::SRP_ST_ERRWAIT;
                end
                srp_pkg::SRP_OP_PPSENSE: begin
                    d.pp_inv = cmd_data[0];
                end
                default: begin
                    d.state = q.state;
                end
            endcase
        end
        if (msg_term) begin
            d.after_term = 1'b1;
        end
        if (dev_clear) begin
            d.obuf_flush = 1'b1;
            d.ibuf_flush = 1'b1;
            d.cmd_abort  = 1'b1;
        end
        for (int g = 0; g < `SRP_NGRP; g++) begin
            d.ev[g] = d.ev[g] | ev_set[g];
        end
        d.standard_event_status = d.standard_event_status | esr_set;
        if (ser_poll) begin
            d.poll_valid = 1'b1;
            d.poll_data  = stb;
        end
        d.srq = mss;
        d.ist = ist;
    end

    // reset holds the flag-set power-on state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q            <= '0;
            q.state      <= srp_pkg::SRP_ST_INIT;
            q.en         <= {`SRP_EN_OTHER_PRESET, `SRP_EN_OPQA_PRESET, `SRP_EN_OPQA_PRESET};
            q.rise       <= {`SRP_NGRP{`SRP_RISE_PRESET}};
            q.fall       <= {`SRP_NGRP{`SRP_FALL_PRESET}};
            q.service_request_enable_mask        <= `SRP_MASK8_CLR;
            q.event_status_enable_mask        <= `SRP_MASK8_CLR;
            q.parallel_poll_enable_mask        <= `SRP_MASK8_CLR;
            q.after_term <= 1'b1;
            q.err_empty  <= 1'b1;
            q.obuf_flush <= 1'b1;
            q.ibuf_flush <= 1'b1;
            q.cmd_abort  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    srp_err_fifo u_errq (
        .clk       (clk),
        .rstn      (rstn),
        .clr       (err_clr),
        .push      (err_push),
        .push_data (err_code),
        .pop       (err_pop),
        .rd_data   (err_rdata),
        .empty     (err_empty),
        .full      ()
    );

    assign resp_valid   = q.resp_valid;
    assign resp_data    = q.resp_data;
    assign poll_valid   = q.poll_valid;
    assign poll_data    = q.poll_data;
    // request is the only unsolicited output
    assign srq          = q.srq;
    // drive own line only during the poll
    assign pp_line_o    = q.ist;
    assign pp_line_oe_n = ~par_poll;
    assign obuf_flush   = q.obuf_flush;
    assign ibuf_flush   = q.ibuf_flush;
    assign cmd_abort    = q.cmd_abort;

endmodule

`default_nettype wire

// ---- pkg/srp_defs.svh ----
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH

// Register select: group in sel[4:3], part in sel[2:0]
`define SRP_GRP_COMMON      2'h0
`define SRP_GRP_OPER        2'h1
`define SRP_GRP_QA          2'h2
`define SRP_GRP_LIM         2'h3

// Parts of the common group
`define SRP_COM_STB         3'h0
`define SRP_COM_ESR         3'h1
`define SRP_COM_SRE         3'h2
`define SRP_COM_ESE         3'h3
`define SRP_COM_PPE         3'h4
`define SRP_COM_IST         3'h5

// Parts of a 16-bit group
`define SRP_PART_COND       3'h0
`define SRP_PART_EVENT      3'h1
`define SRP_PART_ENABLE     3'h2
`define SRP_PART_RISE       3'h3
`define SRP_PART_FALL       3'h4

// Group indices inside the state arrays
`define SRP_IDX_OPER        0
`define SRP_IDX_QA          1
`define SRP_IDX_LIM         2
`define SRP_NGRP            3

// Status summary byte bit positions
`define SRP_STB_ERRQ        2
`define SRP_STB_QA          3
`define SRP_STB_MAV         4
`define SRP_STB_ESB         5
`define SRP_STB_MSS         6
`define SRP_STB_OPER        7

// Summary and trace1 condition positions inside the 16-bit groups
`define SRP_QA_LIM_BIT      10
`define SRP_LIM_TRACE1_BIT  1

// Preset and clear values
`define SRP_MASK8_CLR       8'h00
`define SRP_REG8_CLR        8'h00
`define SRP_EV_CLR          16'h0000
`define SRP_EN_OPQA_PRESET  16'h0000
`define SRP_EN_OTHER_PRESET 16'hffff
`define SRP_RISE_PRESET     16'hffff
`define SRP_FALL_PRESET     16'h0000
`define SRP_DATA_CLR        16'h0000

// Error queue
`define SRP_ERRQ_DEPTH      8
`define SRP_ERRQ_AW         3
`define SRP_NO_ERROR        16'h0000

`endif

// ---- pkg/srp_pkg.sv ----
`include "srp_defs.svh"

package srp_pkg;

    typedef enum logic [2:0] {
        SRP_OP_NOP,
        SRP_OP_WRITE,
        SRP_OP_READ,
        SRP_OP_CLS,
        SRP_OP_PRESET,
        SRP_OP_ERRQ,
        SRP_OP_PPSENSE
    } srp_op_e;

    typedef enum logic [1:0] {
        SRP_ST_INIT,
        SRP_ST_IDLE,
        SRP_ST_ERRWAIT
    } srp_state_e;

    typedef struct packed {
        srp_state_e                        state;
        logic [`SRP_NGRP-1:0][15:0]        ev;
        logic [`SRP_NGRP-1:0][15:0]        en;
        logic [`SRP_NGRP-1:0][15:0]        rise;
        logic [`SRP_NGRP-1:0][15:0]        fall;
        logic [`SRP_NGRP-1:0][15:0]        prev;
        logic [7:0]                        standard_event_status;
        logic [7:0]                        service_request_enable_mask;
        logic [7:0]                        event_status_enable_mask;
        logic [7:0]                        parallel_poll_enable_mask;
        logic                              pp_inv;
        logic                              after_term;
        logic                              err_empty;
        logic                              resp_valid;
        logic [15:0]                       resp_data;
        logic                              poll_valid;
        logic [7:0]                        poll_data;
        logic                              srq;
        logic                              ist;
        logic                              obuf_flush;
        logic                              ibuf_flush;
        logic                              cmd_abort;
    } srp_state_s;

    typedef struct packed {
        logic [`SRP_ERRQ_DEPTH-1:0][15:0]  mem;
        logic [`SRP_ERRQ_AW-1:0]           wptr;
        logic [`SRP_ERRQ_AW-1:0]           rptr;
        logic [`SRP_ERRQ_AW:0]             count;
        logic [15:0]                       rdata;
    } srp_fifo_s;

endpackage

// ---- rtl/srp_err_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.svh"

module srp_err_fifo (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clr,
    input  wire logic        push,
    input  wire logic [15:0] push_data,
    input  wire logic        pop,
    output logic      [15:0] rd_data,
    output logic             empty,
    output logic             full
);

    srp_pkg::srp_fifo_s q;
    srp_pkg::srp_fifo_s d;

    assign rd_data = q.rdata;
    assign empty   = (q.count == '0);
    assign full    = (q.count == (`SRP_ERRQ_AW+1)'(`SRP_ERRQ_DEPTH));

    always_comb begin
        d = q;
        // Clear first so an error logged in the same cycle survives
        if (clr) begin
            d.wptr  = '0;
            d.rptr  = '0;
            d.count = '0;
        end else if (pop && !empty) begin
            d.rdata = q.mem[q.rptr];
            d.rptr  = q.rptr + 1'b1;
            d.count = q.count - 1'b1;
        end
        // A full queue drops new entries; the oldest causes are kept
        if (push && (d.count != (`SRP_ERRQ_AW+1)'(`SRP_ERRQ_DEPTH))) begin
            d.mem[d.wptr] = push_data;
            d.wptr        = d.wptr + 1'b1;
            d.count       = d.count + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// ---- verification/srp_status_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.svh"

module srp_status_monitor (
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic             cmd_valid,
    input wire logic             cmd_ready,
    input wire srp_pkg::srp_op_e cmd_op,
    input wire logic [4:0]       cmd_sel,
    input wire logic             resp_valid,
    input wire logic [15:0]      resp_data,
    input wire logic             msg_term,
    input wire logic             dev_clear,
    input wire logic             ser_poll,
    input wire logic             poll_valid,
    input wire logic [7:0]       poll_data,
    input wire logic             par_poll,
    input wire logic             pp_line_o,
    input wire logic             pp_line_oe_n,
    input wire logic             srq,
    input wire logic             obuf_flush,
    input wire logic             ibuf_flush,
    input wire logic             cmd_abort
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence rd_take_s;
        cmd_valid && cmd_ready && cmd_op == srp_pkg::SRP_OP_READ;
    endsequence
    sequence errq_take_s;
        cmd_valid && cmd_ready && cmd_op == srp_pkg::SRP_OP_ERRQ;
    endsequence
    // Pop needs one dead cycle before the answer
    sequence errq_wait_s;
        !cmd_ready && !resp_valid ##1 resp_valid;
    endsequence
    sequence term_take_s;
        msg_term ##1 (cmd_valid && cmd_ready);
    endsequence

    boot_flush_a: assert property ($rose(rstn) |-> obuf_flush && ibuf_flush && !cmd_ready)
        else $error("no flush at power-on");
    read_answer_a: assert property (rd_take_s |=> resp_valid)
        else $error("read not answered");
    byte_upper_a: assert property (rd_take_s ##0 (cmd_sel[4:3] == `SRP_GRP_COMMON)
        |=> resp_data[15:8] == 8'h00) else $error("byte register too wide");
    ist_match_a: assert property (rd_take_s ##0 (cmd_sel == {`SRP_GRP_COMMON, `SRP_COM_IST})
        |=> resp_data == {15'h0000, pp_line_o}) else $error("status query differs");
    errq_answer_a: assert property (errq_take_s |=> errq_wait_s)
        else $error("error query timing");
    poll_answer_a: assert property (ser_poll |=> poll_valid)
        else $error("serial poll not answered");
    srq_summary_a: assert property (poll_valid |-> srq == poll_data[`SRP_STB_MSS])
        else $error("request and summary differ");
    pp_enable_a: assert property (pp_line_oe_n == !par_poll)
        else $error("poll line enable wrong");
    dcl_flush_a: assert property (dev_clear |=> obuf_flush && ibuf_flush && cmd_abort)
        else $error("device clear did not flush");
    term_flush_a: assert property (term_take_s |=> obuf_flush)
        else $error("no output flush after terminator");
    ibuf_cause_a: assert property ($rose(ibuf_flush) |-> $past(dev_clear))
        else $error("input flush without clear");
endmodule

bind srp_status srp_status_monitor srp_status_monitor_inst (
    .clk, .rstn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_sel, .resp_valid, .resp_data,
    .msg_term, .dev_clear, .ser_poll, .poll_valid, .poll_data, .par_poll, .pp_line_o,
    .pp_line_oe_n, .srq, .obuf_flush, .ibuf_flush, .cmd_abort
);
`default_nettype wire

// ---- verification/srp_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module srp_ctl_model (
    input  wire logic       clk,
    output logic            ser_poll,
    output logic            par_poll,
    input  wire logic       pp_line_o,
    input  wire logic       pp_line_oe_n,
    input  wire logic       poll_valid,
    input  wire logic [7:0] poll_data
);
    logic pp_wire;

    // Pull-up on the line, a released device reads high
    assign pp_wire = pp_line_oe_n ? 1'b1 : pp_line_o;

    initial begin
        ser_poll = 1'b0;
        par_poll = 1'b0;
    end

    task automatic serial_poll(output logic [7:0] b, output logic ok);
        @(negedge clk);
        ser_poll = 1'b1;
        @(negedge clk);
        ser_poll = 1'b0;
        ok = poll_valid;
        b = poll_data;
        @(negedge clk);
    endtask

    // one bit on own line
    // Hold count lets a slow controller be modelled
    task automatic parallel_poll(input int hold, output logic bit_v);
        @(negedge clk);
        par_poll = 1'b1;
        repeat (hold) @(negedge clk);
        bit_v = pp_wire;
        par_poll = 1'b0;
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ---- verification/srp_status_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "srp_defs.svh"

module srp_status_tb_top;
    localparam logic [1:0] GC = `SRP_GRP_COMMON, GO = `SRP_GRP_OPER;
    localparam logic [1:0] GQ = `SRP_GRP_QA, GL = `SRP_GRP_LIM;
    localparam logic [2:0] CO = `SRP_PART_COND, EV = `SRP_PART_EVENT, EN = `SRP_PART_ENABLE;
    localparam logic [2:0] RI = `SRP_PART_RISE, FA = `SRP_PART_FALL, ST = `SRP_COM_STB;
    localparam logic [2:0] ES = `SRP_COM_ESR, SR = `SRP_COM_SRE, SE = `SRP_COM_ESE;
    localparam logic [2:0] PP = `SRP_COM_PPE, IS = `SRP_COM_IST;
    localparam logic [4:0] RSEL [11] = '{{GC, ST}, {GC, ES}, {GC, SR}, {GC, SE}, {GC, PP},
        {GC, 3'h7}, {GO, EN}, {GQ, EN}, {GL, EN}, {GL, RI}, {GQ, FA}};
    localparam logic [15:0] RVAL [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
        16'h0, 16'h0, 16'hffff, 16'hffff, 16'h0};
    logic             clk, rstn, cmd_valid, cmd_ready, resp_valid, msg_term, dev_clear;
    logic             trace1_fail, out_avail, err_push, ser_poll, poll_valid, par_poll;
    logic             pp_line_o, pp_line_oe_n, srq, obuf_flush, ibuf_flush, cmd_abort, rv, pv;
    logic             fl, psc_flag;
    logic [7:0]       kept_sre, kept_ese, kept_ppe;
    logic [4:0]       cmd_sel;
    logic [7:0]       esr_set, poll_data, pb;
    logic [15:0]      cmd_data, resp_data, oper_cond, qa_cond, err_code, rd_d;
    srp_pkg::srp_op_e cmd_op;
    int               mismatches = 0;
    int               num_checks = 0;
    int               cycles = 0;

    srp_status srp_status_inst (
        .clk, .rstn, .psc_flag, .kept_sre, .kept_ese, .kept_ppe,
        .cmd_valid, .cmd_ready, .cmd_op, .cmd_sel, .cmd_data, .resp_valid, .resp_data,
        .msg_term, .dev_clear, .oper_cond, .qa_cond, .lim_cond(16'h0000), .trace1_fail,
        .esr_set, .out_avail, .err_push, .err_code, .ser_poll, .poll_valid, .poll_data,
        .par_poll, .pp_line_o, .pp_line_oe_n, .srq, .obuf_flush, .ibuf_flush, .cmd_abort
    );
    srp_ctl_model srp_ctl_model_inst (
        .clk, .ser_poll, .par_poll, .pp_line_o, .pp_line_oe_n, .poll_valid, .poll_data
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Waits for ready, holds the request over the taking edge
    task automatic op(input srp_pkg::srp_op_e o, input logic [4:0] s, input logic [15:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_op = o;
        cmd_sel = s;
        cmd_data = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        fl = obuf_flush;
        rv = resp_valid;
        rd_d = resp_data;
        @(negedge clk);
        if (o == srp_pkg::SRP_OP_ERRQ) begin
            rv = resp_valid;
            rd_d = resp_data;
        end
    endtask

    task automatic rd(input logic [4:0] s, input logic [15:0] exp);
        op(srp_pkg::SRP_OP_READ, s, 16'h0);
        chk1(rv, 1'b1);
        chk16(rd_d, exp);
    endtask

    task automatic eq(input logic [15:0] exp);
        op(srp_pkg::SRP_OP_ERRQ, 5'h0, 16'h0);
        chk1(rv, 1'b1);
        chk16(rd_d, exp);
    endtask

    task automatic push(input logic [15:0] c);
        err_code = c;
        err_push = 1'b1;
        @(negedge clk);
        err_push = 1'b0;
        @(negedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard, the tests need under two hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        {rstn, cmd_valid, msg_term, dev_clear, trace1_fail, out_avail, err_push} = 7'h0;
        cmd_op = srp_pkg::SRP_OP_NOP;
        {psc_flag, kept_sre, kept_ese, kept_ppe} = 25'h1000000;
        {cmd_sel, cmd_data, oper_cond, qa_cond, err_code, esr_set} = 77'h0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        wt(2);
        op(srp_pkg::SRP_OP_WRITE, {GC, ST}, 16'hffff);
        for (int i = 0; i < 11; i++) rd(RSEL[i], RVAL[i]);
        oper_cond = 16'h0001;
        qa_cond = 16'h0001;
        wt(3);
        rd({GO, EV}, 16'h0001);
        rd({GO, EV}, 16'h0000);
        rd({GQ, CO}, 16'h0001);
        rd({GQ, EV}, 16'h0001);
        op(srp_pkg::SRP_OP_WRITE, {GO, FA}, 16'h0001);
        oper_cond = 16'h0000;
        wt(3);
        rd({GO, EV}, 16'h0001);
        op(srp_pkg::SRP_OP_WRITE, {GQ, EN}, 16'h0400);
        op(srp_pkg::SRP_OP_WRITE, {GC, SR}, 16'h0008);
        op(srp_pkg::SRP_OP_WRITE, {GC, PP}, 16'h0008);
        chk1(srq, 1'b0);
        trace1_fail = 1'b1;
        wt(10);
        chk1(srq, 1'b1);
        srp_ctl_model_inst.serial_poll(pb, pv);
        chk16({8'h00, pb}, 16'h0048);
        chk1(pv, 1'b1);
        srp_ctl_model_inst.parallel_poll(1, pv);
        chk1(pv, 1'b1);
        rd({GC, IS}, 16'h0001);
        op(srp_pkg::SRP_OP_PPSENSE, 5'h0, 16'h0001);
        srp_ctl_model_inst.parallel_poll(4, pv);
        chk1(pv, 1'b0);
        op(srp_pkg::SRP_OP_PPSENSE, 5'h0, 16'h0000);
        rd({GC, ST}, 16'h0048);
        rd({GL, EV}, 16'h0002);
        rd({GQ, EV}, 16'h0400);
        wt(4);
        chk1(srq, 1'b0);
        op(srp_pkg::SRP_OP_WRITE, {GC, SE}, 16'h0001);
        out_avail = 1'b1;
        esr_set = 8'h01;
        wt(1);
        esr_set = 8'h00;
        wt(3);
        rd({GC, ST}, 16'h0030);
        rd({GC, ES}, 16'h0001);
        rd({GC, ES}, 16'h0000);
        out_avail = 1'b0;
        push(16'h0071);
        push(16'h0072);
        wt(3);
        rd({GC, ST}, 16'h0004);
        msg_term = 1'b1;
        wt(1);
        msg_term = 1'b0;
        eq(16'h0071);
        chk1(fl, 1'b1);
        eq(16'h0072);
        chk1(fl, 1'b0);
        eq(16'h0000);
        push(16'h0073);
        esr_set = 8'h02;
        wt(1);
        esr_set = 8'h00;
        op(srp_pkg::SRP_OP_CLS, 5'h0, 16'h0);
        rd({GC, ES}, 16'h0000);
        rd({GC, SR}, 16'h0008);
        eq(16'h0000);
        op(srp_pkg::SRP_OP_WRITE, {GL, RI}, 16'h0000);
        op(srp_pkg::SRP_OP_WRITE, {GO, EN}, 16'hffff);
        op(srp_pkg::SRP_OP_PRESET, 5'h0, 16'h0);
        rd({GL, RI}, 16'hffff);
        rd({GO, EN}, 16'h0000);
        rd({GL, EN}, 16'hffff);
        // Power-on with the clear flag low keeps the three masks
        push(16'h0074);
        psc_flag = 1'b0;
        kept_sre = 8'ha4;
        kept_ese = 8'h21;
        kept_ppe = 8'h81;
        rstn = 1'b0;
        wt(3);
        rstn = 1'b1;
        wt(2);
        rd({GC, SR}, 16'h00a4);
        rd({GC, SE}, 16'h0021);
        rd({GC, PP}, 16'h0081);
        eq(16'h0000);
        dev_clear = 1'b1;
        wt(1);
        dev_clear = 1'b0;
        chk1(obuf_flush & ibuf_flush & cmd_abort, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
